// ---- hw/pcu_map.vh ----
// register map and field layout of the pwm compare-value logic
// assumes byte-addressed offsets on a plain register port
`ifndef PCU_MAP_VH
`define PCU_MAP_VH
`define PCU_GEN0_CMPB_OFF 12'h05c
`define PCU_GEN1_CMPB_OFF 12'h09c
`define PCU_GEN2_CMPB_OFF 12'h0dc
`define PCU_GEN0_CMPA_OFF 12'h058
`define PCU_GEN1_CMPA_OFF 12'h098
`define PCU_GEN2_CMPA_OFF 12'h0d8
`define PCU_GEN_STRIDE 12'h040
`define PCU_GEN_BASE 12'h058
`define PCU_CMP_LSB 0
`define PCU_CMP_MSB 15
`define PCU_CMP_RESET 16'h0000
`define PCU_NUM_GEN 3
`endif

// ---- hw/pcu_cmp_chan.v ----
// one generator's compare pair: pending copy, active copy, match pulse
// assumes counter, load, zero flag and sync request come from the same clock
`timescale 1ns/100ps
`include "pcu_map.vh"
module pcu_cmp_chan #(
  parameter W = 16
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // software side
  input wire wr_a,
  input wire wr_b,
  input wire [W-1:0] wdata,
  input wire sync_mode,
  input wire sync_req,
  // counter side
  input wire [W-1:0] count,
  input wire [W-1:0] load,
  input wire at_zero,
  // results
  output reg [W-1:0] pend_a_reg,
  output reg [W-1:0] pend_b_reg,
  output reg [W-1:0] act_a_reg,
  output reg [W-1:0] act_b_reg,
  output reg pulse_a_reg,
  output reg pulse_b_reg,
  output reg armed_reg
);
  reg dirty_reg;
  wire update;
  // immediate: next zero; sync: first zero after request is seen
  assign update = at_zero & dirty_reg & (~sync_mode | armed_reg);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_a_reg <= `PCU_CMP_RESET;
      pend_b_reg <= `PCU_CMP_RESET;
      act_a_reg <= `PCU_CMP_RESET;
      act_b_reg <= `PCU_CMP_RESET;
      dirty_reg <= 1'b0;
      armed_reg <= 1'b0;
      pulse_a_reg <= 1'b0;
      pulse_b_reg <= 1'b0;
    end else begin
      // a rewrite simply overwrites pending, older value is lost
      if (wr_a) begin
        pend_a_reg <= wdata;
      end
      if (wr_b) begin
        pend_b_reg <= wdata;
      end
      if (update) begin
        act_a_reg <= pend_a_reg;
        act_b_reg <= pend_b_reg;
      end
      // a write landing on the update cycle stays pending
      if (wr_a | wr_b) begin
        dirty_reg <= 1'b1;
      end else if (update) begin
        dirty_reg <= 1'b0;
      end
      // request wins over the clear at counter zero
      if (sync_req) begin
        armed_reg <= 1'b1;
      end else if (at_zero) begin
        armed_reg <= 1'b0;
      end
      // beyond load the counter never gets there; guard explicitly
      pulse_a_reg <= (count == act_a_reg) & (act_a_reg <= load);
      pulse_b_reg <= (count == act_b_reg) & (act_b_reg <= load);
    end
  end
endmodule

// ---- hw/pcu_top.v ----
// compare-value block for the pwm generators: registers and per-generator channels
// assumes counters and load values are supplied by the generator logic on clk
//
// Function
// - each comparator holds a 16-bit writable value in bits 15:0 compared against its generator counter.
// - when the active second compare value equals the counter a single compare pulse is raised.
// - the compare pulse goes both to the output action logic and to the interrupt and trigger enables.
// - a compare value above the load value never produces a pulse.
// - in immediate mode a newly written value becomes active at the next counter zero.
// - in synchronous mode a new value becomes active at the first zero after a synchronous update request.
// - a rewrite before the update takes effect discards the earlier pending value.
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`include "pcu_map.vh"
module pcu_top #(
  parameter W = 16,
  parameter NG = `PCU_NUM_GEN
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register port
  input wire [11:0] addr,
  input wire [31:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [31:0] rdata,
  // generator side, one field per generator
  input wire [NG*W-1:0] counter_value,
  input wire [NG*W-1:0] generator_load_value,
  input wire [NG-1:0] counter_at_zero,
  input wire [NG-1:0] compare_b_update_select,
  input wire [NG-1:0] master_sync_request,
  // compare pulses to action logic
  output wire [NG-1:0] cmp_a_pulse_action,
  output wire [NG-1:0] cmp_b_pulse_action,
  // compare pulses to interrupt and trigger enables
  output wire [NG-1:0] cmp_a_pulse_event,
  output wire [NG-1:0] cmp_b_pulse_event
);
  ////////////////////////////////////////////////////////////////////////
  // distance from a generator's compare a word to its compare b word
  localparam [11:0] B_STEP = `PCU_GEN0_CMPB_OFF - `PCU_GEN_BASE;

  wire [NG-1:0] pa;
  wire [NG-1:0] pb;
  // per-generator read words or-ed in a chain; at most one link is nonzero
  wire [(NG+1)*32-1:0] rd_chain;
  wire [31:0] rdata_next;

  assign rd_chain[31:0] = 32'h0000_0000;

  genvar g;
  generate
    for (g = 0; g < NG; g = g + 1) begin : gen_ch
      localparam [31:0] OFF_A_WIDE = `PCU_GEN_BASE + g * `PCU_GEN_STRIDE;
      localparam [11:0] OFF_A = OFF_A_WIDE[11:0];
      localparam [11:0] OFF_B = OFF_A + B_STEP;
      wire sel_a;
      wire sel_b;
      wire [W-1:0] pend_a;
      wire [W-1:0] pend_b;
      wire [31:0] word;
      assign sel_a = (addr == OFF_A);
      assign sel_b = (addr == OFF_B);
      pcu_cmp_chan #(.W(W)) pcu_cmp_chan_i (
        .clk(clk),
        .rst_n(rst_n),
        .wr_a(wr_en & sel_a),
        .wr_b(wr_en & sel_b),
        .wdata(wdata[`PCU_CMP_MSB:`PCU_CMP_LSB]),
        .sync_mode(compare_b_update_select[g]),
        .sync_req(master_sync_request[g]),
        .count(counter_value[g*W +: W]),
        .load(generator_load_value[g*W +: W]),
        .at_zero(counter_at_zero[g]),
        .pend_a_reg(pend_a),
        .pend_b_reg(pend_b),
        .act_a_reg(),
        .act_b_reg(),
        .pulse_a_reg(pa[g]),
        .pulse_b_reg(pb[g]),
        .armed_reg()
      );
      // reads return the software-written copy; reserved upper half is zero
      assign word = sel_a ? {{(32-W){1'b0}}, pend_a} : (sel_b ? {{(32-W){1'b0}}, pend_b} : 32'h0000_0000);
      assign rd_chain[(g+1)*32 +: 32] = rd_chain[g*32 +: 32] | word;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // same pulse fans out to both consumers
  assign cmp_a_pulse_action = pa;
  assign cmp_b_pulse_action = pb;
  assign cmp_a_pulse_event = pa;
  assign cmp_b_pulse_event = pb;

  ////////////////////////////////////////////////////////////////////////
  // unmapped addresses fall through the chain as zero
  assign rdata_next = rd_chain[NG*32 +: 32];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata <= rdata_next;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule

// ---- tb/pcu_top_properties.sv ----
// port-level assertions for the pwm compare-value block
// assumes default widths and three generators
`timescale 1ns/100ps
module pcu_top_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  // generator side
  input wire logic [47:0] counter_value,
  input wire logic [47:0] generator_load_value,
  input wire logic [2:0] counter_at_zero,
  input wire logic [2:0] compare_b_update_select,
  input wire logic [2:0] master_sync_request,
  // pulses
  input wire logic [2:0] cmp_a_pulse_action,
  input wire logic [2:0] cmp_b_pulse_action,
  input wire logic [2:0] cmp_a_pulse_event,
  input wire logic [2:0] cmp_b_pulse_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence wr_b0;
    wr_en && addr == 12'h05c;
  endsequence
  sequence rd_b0;
    rd_en && addr == 12'h05c;
  endsequence
  read_back_a: assert property (wr_b0 ##1 !(wr_en && addr == 12'h05c) ##1 rd_b0
    |=> rdata == {16'h0000, $past(wdata[15:0], 3)})
    else $error("read-back differs");
  reserved_zero_a: assert property (rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  rdata_idle_a: assert property (!rd_en |=> rdata == 32'h0)
    else $error("read data without read");
  copy_a_a: assert property (cmp_a_pulse_action == cmp_a_pulse_event)
    else $error("a pulse copies differ");
  copy_b_a: assert property (cmp_b_pulse_action == cmp_b_pulse_event)
    else $error("b pulse copies differ");
  load_b_a: assert property (cmp_b_pulse_action[0] |-> $past(counter_value[15:0]) <= $past(generator_load_value[15:0]))
    else $error("b pulse above load");
  load_a_a: assert property (cmp_a_pulse_action[0] |-> $past(counter_value[15:0]) <= $past(generator_load_value[15:0]))
    else $error("a pulse above load");
  // an update two edges back may legally move the matching count
  pulse_hold_a: assert property (cmp_b_pulse_action[0] && $past(cmp_b_pulse_action[0])
    && !$past(counter_at_zero[0], 2) |-> $past(counter_value[15:0]) == $past(counter_value[15:0], 2))
    else $error("pulse on two counts");
endmodule
bind pcu_top pcu_top_properties pcu_top_properties_i (.*);

// ---- tb/pcu_top_tb.sv ----
// self-checking bench for the pwm compare-value block
// assumes default widths; all generators see one counter, gen 0 is judged
`timescale 1ns/100ps
module pcu_top_tb;
  logic clk = 0, rst_n = 0, wr_en = 0, rd_en = 0, zr = 0, sel = 0, rq = 0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [15:0] cnt = 16'h0001, ld = 16'h0064;
  logic [2:0] cmp_a_pulse_action, cmp_b_pulse_action, cmp_a_pulse_event, cmp_b_pulse_event;
  wire [47:0] counter_value = {3{cnt}};
  wire [47:0] generator_load_value = {3{ld}};
  wire [2:0] counter_at_zero = {3{zr}};
  wire [2:0] compare_b_update_select = {3{sel}};
  wire [2:0] master_sync_request = {3{rq}};
  integer error_cnt = 0, checks = 0;
  always #2 clk = ~clk;
  pcu_top pcu_top_i (.*);
  task conclude;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task bad(input string m);
    error_cnt++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task wr(input [11:0] a, input [31:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr_en <= 1;
    @(posedge clk); wr_en <= 0;
  endtask
  task rd(input [11:0] a, input [31:0] e);
    @(posedge clk); addr <= a; rd_en <= 1;
    @(posedge clk); rd_en <= 0;
    #1 checks++;
    if (rdata !== e) bad("read value");
  endtask
  task st(input [15:0] c, input z, input q);
    @(posedge clk); cnt <= c; zr <= z; rq <= q;
  endtask
  // pulse lands one cycle after the counter is driven
  task pk(input [15:0] c, input e);
    st(c, 0, 0);
    @(posedge clk); #1 checks++;
    if (cmp_b_pulse_action[0] !== e || cmp_b_pulse_event[0] !== e) bad("compare pulse");
  endtask
  task pka(input [15:0] c, input e);
    st(c, 0, 0);
    @(posedge clk); #1 checks++;
    if (cmp_a_pulse_action[0] !== e || cmp_a_pulse_event[0] !== e) bad("compare a pulse");
  endtask
  initial begin
    #2000 bad("timeout");
    conclude;
  end
  task sc_regs;
    wr(12'h05c, 32'hffff0005);
    rd(12'h05c, 32'h00000005);
    rd(12'h000, 32'h00000000);
  endtask
  task sc_immediate;
    pk(16'h0005, 0);
    st(16'h0000, 1, 0);
    pk(16'h0005, 1);
  endtask
  task sc_rewrite;
    wr(12'h05c, 32'h00000007);
    wr(12'h05c, 32'h00000009);
    st(16'h0000, 1, 0);
    pk(16'h0007, 0);
    pk(16'h0009, 1);
  endtask
  task sc_load;
    @(posedge clk);
    ld <= 16'h0004;
    wr(12'h05c, 32'h00000006);
    st(16'h0000, 1, 0);
    pk(16'h0006, 0);
  endtask
  task sc_sync;
    @(posedge clk);
    sel <= 1;
    wr(12'h05c, 32'h00000003);
    st(16'h0000, 1, 0);
    pk(16'h0003, 0);
    st(16'h0001, 0, 1);
    st(16'h0000, 1, 0);
    pk(16'h0003, 1);
  endtask
  // compare a rides the same update path as compare b
  task sc_first;
    @(posedge clk);
    sel <= 0;
    wr(12'h058, 32'h00000002);
    rd(12'h058, 32'h00000002);
    pka(16'h0002, 0);
    st(16'h0000, 1, 0);
    pka(16'h0002, 1);
    wr(12'h058, 32'h00000005);
    st(16'h0000, 1, 0);
    pka(16'h0005, 0);
  endtask
  task sc_gens;
    wr(12'h09c, 32'h00001234);
    wr(12'h0d8, 32'h000000ab);
    rd(12'h09c, 32'h00001234);
    rd(12'h0d8, 32'h000000ab);
    rd(12'h0dc, 32'h00000000);
    rd(12'h05c, 32'h00000003);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    sc_regs;
    sc_immediate;
    sc_rewrite;
    sc_load;
    sc_sync;
    sc_first;
    sc_gens;
    conclude;
  end
endmodule
